// ==== bdst_pkg.sv ====
/*
 * Package for the background debug sync responder: timing counts, states.
 * Assumes a 125 MHz system clock standing in for the oscillator-derived
 * clock.
 */
package bdst_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned SYS_CLK_MHZ = 125;
   localparam int unsigned DBG_CLK_DIV = 8;
   localparam int unsigned DLY_DBG_CYC = 16;
   localparam int unsigned RSP_DBG_CYC = 128;
   localparam int unsigned SPD_DBG_CYC = 1;
   localparam int unsigned REQ_DBG_CYC = 128;
   localparam int unsigned BIT_DBG_CYC = 16;
   localparam int unsigned CNT_W = 12;
   localparam int unsigned SYNC_STAGES = 2;

   // -----------------------------------------------------------------
   // States
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_HIGH = 3'b001,
      ST_DELAY = 3'b010,
      ST_DRIVE_LOW = 3'b011,
      ST_SPEEDUP = 3'b100
   } bdst_state_t;
endpackage : bdst_pkg

// ==== bdst_clkdiv.sv ====
/*
 * Debug serial clock divider: one-cycle tick every DIV system clocks.
 * Assumes a single system clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module bdst_clkdiv
   import bdst_pkg::*;
#(
   parameter int unsigned DIV = DBG_CLK_DIV
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Tick out
   output logic tick_o
);
   logic [$clog2(DIV)-1:0] cnt_ff;
   wire wrap = (cnt_ff == ($clog2(DIV))'(DIV - 1));

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cnt_ff <= '0;
      end else if (wrap) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign tick_o = wrap;
endmodule : bdst_clkdiv
`default_nettype wire

// ==== bdst_sync_resp.sv ====
/*
 * Target-side sync responder of the one-wire background debug link, plus
 * the single-step sequencing handshake toward the core.
 * Assumes the debug line wire is resolved outside from the output enable
 * (open drain with pull-up plus active-high speedup of one debug tick, 8 clocks), and that
 * the command receiver and core sit beside this block on sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module bdst_sync_resp
   import bdst_pkg::*;
#(
   parameter int unsigned REQ_CYC = BIT_DBG_CYC,
   parameter int unsigned RSP_CYC = RSP_DBG_CYC,
   parameter int unsigned DLY_CYC = DLY_DBG_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Debug line
   input wire logic debug_line_i,
   output logic debug_line_o,
   output logic debug_line_oe_o,
   // Receiver side
   input wire logic ack_pending_i,
   output logic rx_soft_reset_o,
   output logic ack_cancel_o,
   output logic cmd_edge_o,
   output logic sync_busy_o,
   // Single step
   input wire logic background_debug_mode_i,
   input wire logic single_step_command_i,
   input wire logic instr_done_i,
   output logic user_run_o,
   output logic step_active_o
);
   // -----------------------------------------------------------------
   // Line synchroniser and debug tick
   // -----------------------------------------------------------------
   logic sync1_ff;
   logic sync2_ff;
   logic line_d_ff;
   logic tick;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         line_d_ff <= 1'b1;
      end else begin
         sync1_ff <= debug_line_i;
         sync2_ff <= sync1_ff;
         line_d_ff <= sync2_ff;
      end
   end

   bdst_clkdiv #(.DIV(DBG_CLK_DIV)) u_div (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .tick_o(tick)
   );

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   bdst_state_t st_ff;
   bdst_state_t nxt_st;
   logic [CNT_W-1:0] low_cnt_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic oe_ff;
   logic dout_ff;
   logic nxt_oe;
   logic nxt_dout;

   wire line_low = ~sync2_ff;
   wire fall = line_d_ff & ~sync2_ff;
   wire is_idle = (st_ff == ST_IDLE);
   // Low for REQ_CYC debug ticks, by default BIT_DBG_CYC, which is one bit time
   wire req_hit = is_idle & line_low & tick &
      (low_cnt_ff == CNT_W'(REQ_CYC - 1));
   wire cnt_last_dly = (cnt_ff == CNT_W'(DLY_CYC - 1));
   wire cnt_last_rsp = (cnt_ff == CNT_W'(RSP_CYC - 1));
   wire cnt_last_spd = (cnt_ff == CNT_W'(SPD_DBG_CYC - 1));

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         low_cnt_ff <= '0;
      end else if (!line_low || !is_idle) begin
         low_cnt_ff <= '0;
      end else if (tick && low_cnt_ff != CNT_W'(REQ_CYC - 1)) begin
         low_cnt_ff <= low_cnt_ff + 1'b1;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_oe = 1'b0;
      nxt_dout = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            nxt_cnt = '0;
            if (req_hit) begin
               nxt_st = ST_WAIT_HIGH;
            end
         end
         ST_WAIT_HIGH: begin
            nxt_cnt = '0;
            if (!line_low) begin
               nxt_st = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (tick) begin
               if (cnt_last_dly) begin
                  nxt_st = ST_DRIVE_LOW;
                  nxt_cnt = '0;
                  nxt_oe = 1'b1;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
         end
         ST_DRIVE_LOW: begin
            nxt_oe = 1'b1;
            if (tick) begin
               if (cnt_last_rsp) begin
                  nxt_st = ST_SPEEDUP;
                  nxt_cnt = '0;
                  nxt_dout = 1'b1;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
         end
         ST_SPEEDUP: begin
            nxt_oe = 1'b1;
            nxt_dout = 1'b1;
            if (tick && cnt_last_spd) begin
               nxt_st = ST_IDLE;
               nxt_oe = 1'b0;
               nxt_dout = 1'b0;
               nxt_cnt = '0;
            end
         end
         default: begin
            nxt_st = ST_IDLE;
            nxt_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         st_ff <= ST_IDLE;
         cnt_ff <= '0;
         oe_ff <= 1'b0;
         dout_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         oe_ff <= nxt_oe;
         dout_ff <= nxt_dout;
      end
   end

   assign debug_line_o = dout_ff;
   assign debug_line_oe_o = oe_ff;
   // Soft reset of the receiver, same as a time-out
   assign rx_soft_reset_o = req_hit;
   assign ack_cancel_o = req_hit & ack_pending_i;
   assign cmd_edge_o = is_idle & fall;
   assign sync_busy_o = ~is_idle;

   // -----------------------------------------------------------------
   // Single-step sequencing
   // -----------------------------------------------------------------
   logic step_ff;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         step_ff <= 1'b0;
      end else if (step_ff && instr_done_i) begin
         step_ff <= 1'b0;
      end else if (!step_ff && single_step_command_i &&
                   background_debug_mode_i) begin
         step_ff <= 1'b1;
      end
   end

   assign user_run_o = step_ff;
   assign step_active_o = step_ff;
endmodule : bdst_sync_resp
`default_nettype wire

// ==== bdst_sync_monitor.sv ====
/* Checker for the sync responder; sees only the top module's ports. */
`timescale 1ns/1ps
`default_nettype none
module bdst_sync_monitor (
   input wire logic sys_clk_i, resetn_i, debug_line_i, debug_line_o,
   input wire logic debug_line_oe_o, ack_pending_i, rx_soft_reset_o,
   input wire logic ack_cancel_o, cmd_edge_o, sync_busy_o, user_run_o,
   input wire logic background_debug_mode_i, single_step_command_i,
   input wire logic instr_done_i, step_active_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   logic [11:0] low_ff;
   // Length of the current device low drive in clocks
   always_ff @(posedge sys_clk_i)
      low_ff <= (resetn_i && debug_line_oe_o && !debug_line_o) ?
         low_ff + 12'h001 : 12'h000;
   low_len_a: assert property (debug_line_oe_o && debug_line_o &&
      !$past(debug_line_o) |-> low_ff == 12'h400)
      else $error("reply low time wrong");
   speedup_len_a: assert property ($rose(debug_line_oe_o && debug_line_o)
      |-> (debug_line_oe_o && debug_line_o)[*8] ##1 !debug_line_oe_o)
      else $error("speedup length wrong");
   drive_low_a: assert property ($rose(debug_line_oe_o) |-> !debug_line_o)
      else $error("reply does not start low");
   oe_busy_a: assert property (debug_line_oe_o |-> sync_busy_o)
      else $error("drive outside sync");
   ack_cancel_a: assert property (ack_cancel_o |->
      ack_pending_i && rx_soft_reset_o)
      else $error("bad cancel");
   edge_idle_a: assert property (cmd_edge_o |->
      !rx_soft_reset_o && !debug_line_oe_o)
      else $error("edge while busy");
   step_go_a: assert property (background_debug_mode_i &&
      single_step_command_i && !user_run_o |=> user_run_o)
      else $error("step not started");
   step_end_a: assert property (user_run_o && instr_done_i &&
      !single_step_command_i |=> !user_run_o)
      else $error("step not ended");
   step_same_a: assert property (step_active_o == user_run_o)
      else $error("step flags differ");
   cover property ($fell(debug_line_oe_o));
   cover property (ack_cancel_o);
   cover property ($fell(user_run_o));
endmodule : bdst_sync_monitor
bind bdst_sync_resp bdst_sync_monitor mon (.*);
`default_nettype wire

// ==== bdst_host_pod.sv ====
/* Debug host pod model: sync request, speedup, reply timing.
   Assumes the bench resolves the line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module bdst_host_pod (
   input wire logic sys_clk_i,
   input wire logic debug_line_i,
   input wire logic go_i,
   input wire logic [11:0] len_i,
   output logic drv_low_o,
   output logic drv_high_o,
   output logic [11:0] meas_o
);
   logic [11:0] cnt;
   initial begin
      drv_low_o = 1'b0;
      drv_high_o = 1'b0;
   end
   always @(posedge go_i) begin
      #1 drv_low_o = 1'b1;
      repeat (len_i) @(posedge sys_clk_i);
      #1 drv_low_o = 1'b0;
      drv_high_o = 1'b1;
      @(posedge sys_clk_i);
      #1 drv_high_o = 1'b0;
   end
   // Low time of the reply sets the bit timing
   always @(posedge sys_clk_i) begin
      // A new request throws away the previous measurement
      if (go_i) meas_o <= 12'h000;
      if (!debug_line_i && !drv_low_o) cnt <= cnt + 12'h001;
      else begin
         if (cnt != 12'h000 && !go_i) meas_o <= cnt;
         cnt <= 12'h000;
      end
   end
endmodule : bdst_host_pod
`default_nettype wire

// ==== test_background_debug_sync_trace.sv ====
/* Bench for the sync responder with a host pod model.
   Assumes open-drain line with pull-up, resolved here. */
`timescale 1ns/1ps
`default_nettype none
module test_background_debug_sync_trace;
   import bdst_pkg::*;
   logic sys_clk_i, resetn_i, ack_pending_i, go_i;
   logic background_debug_mode_i, single_step_command_i, instr_done_i;
   logic [11:0] len_i, meas_o;
   logic debug_line_o, debug_line_oe_o, rx_soft_reset_o, ack_cancel_o;
   logic cmd_edge_o, sync_busy_o, user_run_o, step_active_o;
   logic drv_low_o, drv_high_o, s_seen, c_seen, e_seen;
   wire logic debug_line_i;
   int fail_count, checks_done, seed, cyc, r;
   bdst_sync_resp uut (.*);
   bdst_host_pod pod (.*);
   // Pull-up; the host's speedup drive pulls the line high as well
   assign debug_line_i = drv_high_o ||
      !(drv_low_o || (debug_line_oe_o && !debug_line_o));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (rx_soft_reset_o) s_seen <= 1'b1;
      if (ack_cancel_o) c_seen <= 1'b1;
      if (cmd_edge_o) e_seen <= 1'b1;
      if (cyc == 30000) begin
         fail_count++;
         stop_test;
      end
   end
   task chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task host(input logic [11:0] n);
      s_seen = 1'b0;
      c_seen = 1'b0;
      e_seen = 1'b0;
      len_i = n;
      go_i = 1'b1;
      @(posedge sys_clk_i);
      #1 go_i = 1'b0;
      repeat (n) @(posedge sys_clk_i);
      for (int i = 0; i < 2000 && sync_busy_o !== 1'b0; i++)
         @(posedge sys_clk_i);
      repeat (4) @(posedge sys_clk_i);
      #1;
   endtask : host
   task sync(input logic ap);
      ack_pending_i = ap;
      host(12'h400 + 12'(($random(seed) & 63)));
      ack_pending_i = 1'b0;
      chk(12'(s_seen), 12'h001);
      chk(12'(c_seen), 12'(ap));
      chk(meas_o, 12'h400);
      chk(12'(debug_line_oe_o), 12'h000);
      chk(12'(sync_busy_o), 12'h000);
   endtask : sync
   task stp(input logic m);
      background_debug_mode_i = m;
      single_step_command_i = 1'b1;
      @(posedge sys_clk_i);
      #1 single_step_command_i = 1'b0;
      chk(12'(user_run_o), 12'(m));
      instr_done_i = 1'b1;
      @(posedge sys_clk_i);
      #1 instr_done_i = 1'b0;
      chk(12'(user_run_o), 12'h000);
   endtask : stp
   task stop_test;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial begin
      seed = 48509;
      cyc = 0;
      {resetn_i, ack_pending_i, go_i, instr_done_i} = 4'h0;
      {background_debug_mode_i, single_step_command_i} = 2'h0;
      len_i = 12'h000;
      repeat (16) @(posedge sys_clk_i);
      #1 resetn_i = 1'b1;
      sync(1'b1);
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         sync(r[0]);
      end
      host(12'h008);
      chk(12'(e_seen), 12'h001);
      chk(12'(s_seen), 12'h000);
      stp(1'b1);
      stp(1'b0);
      stop_test;
   end
endmodule : test_background_debug_sync_trace
`default_nettype wire
